// ===== rtl/drt_decoder.sv
// Purpose: Register transfer part of a byte coded interpreter
// Assumes: Program bytes arrive in order with valid and ready
// Notes:   Out of scope opcodes are passed on after their operands
`timescale 1ns/1ps
`include "drt_params.svh"

// Function
// RULE1 - Upper nibble row, lower nibble column decode
// RULE2 - Flags reflect completed instruction, else kept
// RULE3 - Zero, positive, negative set flags accordingly
// RULE4 - A0-A5 copy accumulator into slot
// RULE5 - A6-AB copy slot into accumulator
// RULE6 - 90-95 copy operand register into slot
// RULE7 - 96-9B copy slot into operand register
// RULE8 - B9 copies accumulator to operand register
// RULE9 - BA copies operand register to accumulator
// RULE10 - D7 swaps, flags from new accumulator
// RULE11 - C0-C7 store, address from opcode plus byte
// RULE12 - Store four bytes, high first, flags kept
// RULE13 - Sign in bit seven above top digits
// RULE14 - Load four bytes into operand register, restore sign
// RULE15 - EEPROM transfers push PC+2, then pop
// RULE16 - Floating operand count is low minus high plus one
// RULE17 - Byte operand taken from following byte
// RULE18 - Fixed attached form takes one trailing byte
module drt_decoder (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_data,
  input  wire logic [10:0] in_pc,
  output logic             in_ready,
  output logic             ee_req,
  output logic             ee_we,
  output logic      [10:0] ee_addr,
  output logic      [7:0]  ee_wdata,
  input  wire logic [7:0]  ee_rdata,
  input  wire logic        ee_ack,
  output logic             stack_push,
  output logic      [10:0] stack_push_pc,
  output logic             stack_pop,
  output logic             positive_flag,
  output logic             negative_flag,
  output logic             zero_flag,
  output logic      [35:0] main_accumulator,
  output logic      [35:0] operand_register,
  output logic             instr_done,
  output logic             other_valid,
  output logic      [7:0]  other_opcode,
  output logic      [7:0]  other_operand
);

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [2:0] flags_of(input drt_pkg::drt_value_t v);
    logic zero;
    zero = (v[31:0] == 32'h0000_0000);
    if (zero) begin
      flags_of = `DRT_FLAGS_ZERO;                          // [RULE3]
    end else if (v[35:32] != `DRT_POS_NIBBLE) begin
      flags_of = 3'b010;                                   // [RULE3]
    end else begin
      flags_of = 3'b100;                                   // [RULE3]
    end
  endfunction

  function automatic drt_pkg::drt_class_e class_of(input logic [7:0] op);
    logic [3:0] row;
    row = op[7:4];                                         // [RULE1]
    if (row == `DRT_ROW_EEPROM) begin
      class_of = drt_pkg::DRT_CLS_EE;
    end else if (op == `DRT_OP_FLOAT) begin
      class_of = drt_pkg::DRT_CLS_FLOAT;
    end else if (op == `DRT_OP_MEASURE) begin
      class_of = drt_pkg::DRT_CLS_FIXED;
    end else if (row == `DRT_ROW_LOAD_CONST || row == `DRT_ROW_CALL
                 || row == `DRT_ROW_JUMP_Z || row == `DRT_ROW_JUMP
                 || op == `DRT_OP_LOAD_TIM_L || op == `DRT_OP_LOAD_TIM_S
                 || op == `DRT_OP_LOAD_CNT_2 || op == `DRT_OP_LOAD_CNT_1) begin
      class_of = drt_pkg::DRT_CLS_BYTE;
    end else begin
      class_of = drt_pkg::DRT_CLS_NONE;
    end
  endfunction

  function automatic logic [31:0] pack_value(input drt_pkg::drt_value_t v);
    pack_value = {(v[35:32] != `DRT_POS_NIBBLE), v[30:0]}; // [RULE13]
  endfunction

  function automatic drt_pkg::drt_value_t unpack_value(input logic [31:0] b);
    logic [3:0] sign;
    sign = b[31] ? `DRT_NEG_NIBBLE : `DRT_POS_NIBBLE;      // [RULE14]
    unpack_value = {sign, 1'b0, b[30:0]};                  // [RULE13]
  endfunction

  // ****************************************
  // State
  // ****************************************
  drt_pkg::drt_state_e  state_ff,    nxt_state;
  logic [7:0]           opcode_ff,   nxt_opcode;
  logic [7:0]           operand_ff,  nxt_operand;
  logic [10:0]          pc_ff,       nxt_pc;
  drt_pkg::drt_value_t  acc_ff,      nxt_acc;
  drt_pkg::drt_value_t  opd_ff,      nxt_opd;
  drt_pkg::drt_value_t  slot_ff      [`DRT_SLOT_COUNT];
  drt_pkg::drt_value_t  nxt_slot     [`DRT_SLOT_COUNT];
  logic [2:0]           flags_ff,    nxt_flags;
  logic [4:0]           cnt_ff,      nxt_cnt;
  logic                 ready_ff,    nxt_ready;
  logic                 push_ff,     nxt_push;
  logic [10:0]          push_pc_ff,  nxt_push_pc;
  logic                 pop_ff,      nxt_pop;
  logic                 done_ff,     nxt_done;
  logic                 other_ff,    nxt_other;
  logic                 seq_go_ff,   nxt_seq_go;
  logic                 seq_we_ff,   nxt_seq_we;
  logic [10:0]          seq_addr_ff, nxt_seq_addr;
  logic [31:0]          seq_data_ff, nxt_seq_data;
  logic                 seq_done;
  logic [31:0]          seq_rdata;
  logic                 take;
  logic [3:0]           col;
  logic [4:0]           span;

  assign take = in_valid && ready_ff;
  assign col  = in_data[3:0];                              // [RULE1]
  assign span = {1'b0, in_data[3:0]} - {1'b0, in_data[7:4]} + 5'h01;

  // ****************************************
  // Decode and execute
  // ****************************************
  always_comb begin
    nxt_state    = state_ff;
    nxt_opcode   = opcode_ff;
    nxt_operand  = operand_ff;
    nxt_pc       = pc_ff;
    nxt_acc      = acc_ff;
    nxt_opd      = opd_ff;
    nxt_slot     = slot_ff;
    nxt_flags    = flags_ff;                               // [RULE2]
    nxt_cnt      = cnt_ff;
    nxt_push     = 1'b0;
    nxt_push_pc  = push_pc_ff;
    nxt_pop      = 1'b0;
    nxt_done     = 1'b0;
    nxt_other    = 1'b0;
    nxt_seq_go   = 1'b0;
    nxt_seq_we   = seq_we_ff;
    nxt_seq_addr = seq_addr_ff;
    nxt_seq_data = seq_data_ff;
    unique case (state_ff)
      drt_pkg::DRT_IDLE: begin
        if (take) begin
          nxt_opcode  = in_data;
          nxt_operand = 8'h00;
          nxt_pc      = in_pc;
          nxt_done    = 1'b1;
          if (in_data[7:4] == `DRT_ROW_ACC_SLOT && col <= `DRT_COL_SLOT_LAST) begin
            nxt_slot[col[2:0]] = acc_ff;                   // [RULE4]
            nxt_flags = flags_of(acc_ff);                  // [RULE4]
          end else if (in_data[7:4] == `DRT_ROW_ACC_SLOT && col >= `DRT_COL_READ_BASE
                       && col <= `DRT_COL_READ_LAST) begin
            nxt_acc   = slot_ff[3'(col - `DRT_COL_READ_BASE)];            // [RULE5]
            nxt_flags = flags_of(slot_ff[3'(col - `DRT_COL_READ_BASE)]);  // [RULE5]
          end else if (in_data[7:4] == `DRT_ROW_OPD_SLOT && col <= `DRT_COL_SLOT_LAST) begin
            nxt_slot[col[2:0]] = opd_ff;                   // [RULE6]
            nxt_flags = flags_of(opd_ff);                  // [RULE6]
          end else if (in_data[7:4] == `DRT_ROW_OPD_SLOT && col >= `DRT_COL_READ_BASE
                       && col <= `DRT_COL_READ_LAST) begin
            nxt_opd   = slot_ff[3'(col - `DRT_COL_READ_BASE)];            // [RULE7]
            nxt_flags = flags_of(slot_ff[3'(col - `DRT_COL_READ_BASE)]);  // [RULE7]
          end else if (in_data == `DRT_OP_ACC_TO_OPD) begin
            nxt_opd   = acc_ff;                            // [RULE8]
            nxt_flags = flags_of(acc_ff);                  // [RULE8]
          end else if (in_data == `DRT_OP_OPD_TO_ACC) begin
            nxt_acc   = opd_ff;                            // [RULE9]
            nxt_flags = flags_of(opd_ff);                  // [RULE9]
          end else if (in_data == `DRT_OP_SWAP) begin
            nxt_acc   = opd_ff;                            // [RULE10]
            nxt_opd   = acc_ff;                            // [RULE10]
            nxt_flags = flags_of(opd_ff);                  // [RULE10]
          end else if (class_of(in_data) != drt_pkg::DRT_CLS_NONE) begin
            nxt_done  = 1'b0;
            nxt_state = drt_pkg::DRT_OPND;                 // [RULE17]
          end else begin
            nxt_other = 1'b1;
          end
        end
      end
      drt_pkg::DRT_OPND: begin
        if (take) begin
          nxt_operand = in_data;                           // [RULE17]
          unique case (class_of(opcode_ff))
            drt_pkg::DRT_CLS_EE: begin
              nxt_seq_go   = 1'b1;
              nxt_seq_we   = !opcode_ff[`DRT_EE_LOAD_BIT];
              nxt_seq_addr = {opcode_ff[`DRT_EE_ADDR_HI_W-1:0], in_data};  // [RULE11]
              nxt_seq_data = pack_value(acc_ff);           // [RULE12]
              nxt_push     = 1'b1;                         // [RULE15]
              nxt_push_pc  = pc_ff + `DRT_PC_STEP;         // [RULE15]
              nxt_state    = drt_pkg::DRT_EE;
            end
            drt_pkg::DRT_CLS_FIXED: begin
              nxt_cnt   = `DRT_FIXED_BYTES;                // [RULE18]
              nxt_state = drt_pkg::DRT_SKIP;
            end
            drt_pkg::DRT_CLS_FLOAT: begin
              if (in_data[3:0] < in_data[7:4]) begin
                nxt_other = 1'b1;
                nxt_done  = 1'b1;
                nxt_state = drt_pkg::DRT_IDLE;
              end else begin
                nxt_cnt   = span;                          // [RULE16]
                nxt_state = drt_pkg::DRT_SKIP;
              end
            end
            default: begin
              nxt_other = 1'b1;
              nxt_done  = 1'b1;
              nxt_state = drt_pkg::DRT_IDLE;
            end
          endcase
        end
      end
      drt_pkg::DRT_SKIP: begin
        if (take) begin
          nxt_cnt = cnt_ff - `DRT_ONE_BYTE;                // [RULE16] [RULE18]
          if (cnt_ff == `DRT_ONE_BYTE) begin
            nxt_other = 1'b1;
            nxt_done  = 1'b1;
            nxt_state = drt_pkg::DRT_IDLE;
          end
        end
      end
      drt_pkg::DRT_EE: begin
        if (seq_done) begin
          if (!seq_we_ff) begin
            nxt_opd = unpack_value(seq_rdata);             // [RULE14]
          end
          nxt_pop   = 1'b1;                                // [RULE15]
          nxt_state = drt_pkg::DRT_POP;
        end
      end
      drt_pkg::DRT_POP: begin
        nxt_done  = 1'b1;
        nxt_state = drt_pkg::DRT_IDLE;
      end
      default: begin
        nxt_state = drt_pkg::DRT_IDLE;
      end
    endcase
    nxt_ready = (nxt_state == drt_pkg::DRT_IDLE) || (nxt_state == drt_pkg::DRT_OPND)
                || (nxt_state == drt_pkg::DRT_SKIP);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff    <= drt_pkg::DRT_IDLE;
      opcode_ff   <= 8'h00;
      operand_ff  <= 8'h00;
      pc_ff       <= 11'h000;
      acc_ff      <= `DRT_VALUE_RESET;
      opd_ff      <= `DRT_VALUE_RESET;
      for (int i = 0; i < `DRT_SLOT_COUNT; i++) begin
        slot_ff[i] <= `DRT_VALUE_RESET;
      end
      flags_ff    <= `DRT_FLAGS_ZERO;
      cnt_ff      <= 5'h00;
      ready_ff    <= 1'b1;
      push_ff     <= 1'b0;
      push_pc_ff  <= 11'h000;
      pop_ff      <= 1'b0;
      done_ff     <= 1'b0;
      other_ff    <= 1'b0;
      seq_go_ff   <= 1'b0;
      seq_we_ff   <= 1'b0;
      seq_addr_ff <= 11'h000;
      seq_data_ff <= 32'h0000_0000;
    end else begin
      state_ff    <= nxt_state;
      opcode_ff   <= nxt_opcode;
      operand_ff  <= nxt_operand;
      pc_ff       <= nxt_pc;
      acc_ff      <= nxt_acc;
      opd_ff      <= nxt_opd;
      slot_ff     <= nxt_slot;
      flags_ff    <= nxt_flags;
      cnt_ff      <= nxt_cnt;
      ready_ff    <= nxt_ready;
      push_ff     <= nxt_push;
      push_pc_ff  <= nxt_push_pc;
      pop_ff      <= nxt_pop;
      done_ff     <= nxt_done;
      other_ff    <= nxt_other;
      seq_go_ff   <= nxt_seq_go;
      seq_we_ff   <= nxt_seq_we;
      seq_addr_ff <= nxt_seq_addr;
      seq_data_ff <= nxt_seq_data;
    end
  end

  // ****************************************
  // EEPROM sequencer
  // ****************************************
  drt_ee_seq u_ee_seq (
    .clock     (clock),
    .reset_n   (reset_n),
    .start     (seq_go_ff),
    .write     (seq_we_ff),
    .base_addr (seq_addr_ff),
    .wdata     (seq_data_ff),
    .ee_ack    (ee_ack),
    .ee_rdata  (ee_rdata),
    .ee_req    (ee_req),
    .ee_we     (ee_we),
    .ee_addr   (ee_addr),
    .ee_wdata  (ee_wdata),
    .done      (seq_done),
    .rdata     (seq_rdata)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign in_ready         = ready_ff;
  assign stack_push       = push_ff;
  assign stack_push_pc    = push_pc_ff;
  assign stack_pop        = pop_ff;
  assign positive_flag    = flags_ff[2];
  assign negative_flag    = flags_ff[1];
  assign zero_flag        = flags_ff[0];
  assign main_accumulator = acc_ff;
  assign operand_register = opd_ff;
  assign instr_done       = done_ff;
  assign other_valid      = other_ff;
  assign other_opcode     = opcode_ff;
  assign other_operand    = operand_ff;

endmodule

// ===== rtl/drt_ee_seq.sv
// Purpose: Four byte EEPROM transfer sequencer
// Assumes: EEPROM acknowledges each held request with one ack pulse
// Notes:   Outputs registered
`timescale 1ns/1ps
`include "drt_params.svh"

module drt_ee_seq (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        start,
  input  wire logic        write,
  input  wire logic [10:0] base_addr,
  input  wire logic [31:0] wdata,
  input  wire logic        ee_ack,
  input  wire logic [7:0]  ee_rdata,
  output logic             ee_req,
  output logic             ee_we,
  output logic      [10:0] ee_addr,
  output logic      [7:0]  ee_wdata,
  output logic             done,
  output logic      [31:0] rdata
);

  logic        req_ff,   nxt_req;
  logic        we_ff,    nxt_we;
  logic [10:0] addr_ff,  nxt_addr;
  logic [31:0] buf_ff,   nxt_buf;
  logic [1:0]  idx_ff,   nxt_idx;
  logic        done_ff,  nxt_done;

  // ****************************************
  // Byte sequencing
  // ****************************************
  always_comb begin
    nxt_req  = req_ff;
    nxt_we   = we_ff;
    nxt_addr = addr_ff;
    nxt_buf  = buf_ff;
    nxt_idx  = idx_ff;
    nxt_done = 1'b0;
    if (start && !req_ff) begin
      nxt_req  = 1'b1;
      nxt_we   = write;
      nxt_addr = base_addr;
      nxt_buf  = wdata;
      nxt_idx  = 2'h0;
    end else if (req_ff && ee_ack) begin
      // Most significant byte goes first
      nxt_buf  = {buf_ff[23:0], ee_rdata};  // [RULE12] [RULE14]
      nxt_addr = addr_ff + 11'h001;
      nxt_idx  = idx_ff + 2'h1;
      if (idx_ff == `DRT_EE_LAST_BYTE) begin
        nxt_req  = 1'b0;
        nxt_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      req_ff  <= 1'b0;
      we_ff   <= 1'b0;
      addr_ff <= 11'h000;
      buf_ff  <= 32'h0000_0000;
      idx_ff  <= 2'h0;
      done_ff <= 1'b0;
    end else begin
      req_ff  <= nxt_req;
      we_ff   <= nxt_we;
      addr_ff <= nxt_addr;
      buf_ff  <= nxt_buf;
      idx_ff  <= nxt_idx;
      done_ff <= nxt_done;
    end
  end

  assign ee_req   = req_ff;
  assign ee_we    = we_ff;
  assign ee_addr  = addr_ff;
  assign ee_wdata = buf_ff[31:24];
  assign done     = done_ff;
  assign rdata    = buf_ff;

endmodule

// ===== rtl/drt_params.svh
// Purpose: Named constants of the register transfer decoder
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef DRT_PARAMS_SVH
`define DRT_PARAMS_SVH

// Opcode map rows and columns
`define DRT_ROW_ACC_SLOT    4'hA
`define DRT_ROW_OPD_SLOT    4'h9
`define DRT_ROW_EEPROM      4'hC
`define DRT_ROW_LOAD_CONST  4'h5
`define DRT_ROW_CALL        4'h6
`define DRT_ROW_JUMP_Z      4'h7
`define DRT_ROW_JUMP        4'h8
`define DRT_COL_SLOT_BASE   4'h0
`define DRT_COL_SLOT_LAST   4'h5
`define DRT_COL_READ_BASE   4'h6
`define DRT_COL_READ_LAST   4'hB
`define DRT_OP_ACC_TO_OPD   8'hB9
`define DRT_OP_OPD_TO_ACC   8'hBA
`define DRT_OP_SWAP         8'hD7
`define DRT_OP_ROUND_BY_TWO 8'hE1
`define DRT_OP_LOAD_TIM_L   8'hD0
`define DRT_OP_LOAD_TIM_S   8'hD1
`define DRT_OP_LOAD_CNT_2   8'hDE
`define DRT_OP_LOAD_CNT_1   8'hDF
`define DRT_OP_MEASURE      8'hAF
`define DRT_OP_FLOAT        8'hF0

// Encoding of an EEPROM transfer
`define DRT_EE_LOAD_BIT     3
`define DRT_EE_ADDR_HI_W    3
`define DRT_EE_LAST_BYTE    2'h3
`define DRT_SIGN_BIT        7
`define DRT_NEG_NIBBLE      4'hF
`define DRT_POS_NIBBLE      4'h0
`define DRT_PC_STEP         11'h002

// Reset values and counts
`define DRT_VALUE_RESET     36'h0_0000_0000
`define DRT_FLAGS_ZERO      3'b101
`define DRT_SLOT_COUNT      6
`define DRT_FIXED_BYTES     5'h01
`define DRT_ONE_BYTE        5'h01

`endif

// ===== rtl/drt_pkg.sv
// Purpose: Types of the register transfer decoder
// Assumes: Used as drt_pkg::name
// Notes:   No constants beyond types
package drt_pkg;

  typedef logic [35:0] drt_value_t;

  typedef enum logic [4:0] {
    DRT_IDLE = 5'h01,
    DRT_OPND = 5'h02,
    DRT_SKIP = 5'h04,
    DRT_EE   = 5'h08,
    DRT_POP  = 5'h10
  } drt_state_e;

  typedef enum logic [2:0] {
    DRT_CLS_NONE  = 3'h0,
    DRT_CLS_BYTE  = 3'h1,
    DRT_CLS_FIXED = 3'h2,
    DRT_CLS_FLOAT = 3'h3,
    DRT_CLS_EE    = 3'h4
  } drt_class_e;

endpackage

// ===== tb/decimal_register_transfer_decoder_tb_top.sv
// Purpose: Self checking bench of the register transfer decoder
// Assumes: EEPROM model on the far side
// Notes:   Random ops from a fixed seed
`timescale 1ns/1ps
module decimal_register_transfer_decoder_tb_top;
  logic        clock, reset_n, in_valid, in_ready, ee_req, ee_we, ee_ack, instr_done;
  logic        stack_push, stack_pop, positive_flag, negative_flag, zero_flag, other_valid;
  logic [7:0]  in_data, ee_wdata, ee_rdata, other_opcode, other_operand;
  logic [10:0] in_pc, ee_addr, stack_push_pc, pc, push_pc;
  logic [35:0] main_accumulator, operand_register, racc, ropd;
  logic [35:0] rslot [6];
  logic [7:0]  ops [27];
  logic [3:0]  wait_cycles;
  logic [2:0]  rflg;
  logic [15:0] seed;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          pushes = 0;
  int          pops = 0;
  drt_decoder DUT (.*);
  drt_eeprom_model u_mem (.*);
  // ****************************
  // Clock, monitor, helpers
  // ****************************
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (stack_push === 1'b1) begin
      pushes <= pushes + 1;
      push_pc <= stack_push_pc;
    end
    if (stack_pop === 1'b1) pops <= pops + 1;
    if (cyc == 40000) begin
      fail_count++;
      finish_test();
    end
  end
  function automatic logic [7:0] rnd8();
    seed = {seed[14:0], ^(seed & 16'hB400)};
    return seed[7:0];
  endfunction
  function automatic logic [2:0] flg(input logic [35:0] v);
    if (v[31:0] == 32'h0) return 3'h5;
    return (v[35:32] != 4'h0) ? 3'h2 : 3'h4;
  endfunction
  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic check_state();
    chk(main_accumulator, racc, "acc");
    chk(operand_register, ropd, "opd");
    chk(36'({positive_flag, negative_flag, zero_flag}), 36'(rflg), "flags");
  endtask
  task automatic wait_hi(input int sel);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while ((sel == 0 ? in_ready : sel == 1 ? instr_done : other_valid) !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      fail_count++;
      $display("unexpected at %0t: handshake missing", $time);
    end
  endtask
  task automatic send(input logic [7:0] b);
    in_valid <= 1'b1;
    in_data <= b;
    in_pc <= pc;
    wait_hi(0);
    pc = pc + 11'h001;
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    in_valid <= 1'b0;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    racc = 36'h0;
    ropd = 36'h0;
    rflg = 3'h5;
    for (int i = 0; i < 6; i++) rslot[i] = 36'h0;
    @(posedge clock);
  endtask
  // ****************************
  // Operations
  // ****************************
  task automatic reg_op(input logic [7:0] op);
    int n;
    n = op[3:0] < 4'h6 ? op[3:0] : op[3:0] - 4'h6;
    if (op[7:4] == 4'hA && op[3:0] < 4'h6) rslot[n] = racc;
    else if (op[7:4] == 4'hA) racc = rslot[n];
    else if (op[7:4] == 4'h9 && op[3:0] < 4'h6) rslot[n] = ropd;
    else if (op[7:4] == 4'h9) ropd = rslot[n];
    else if (op == 8'hB9) ropd = racc;
    else if (op == 8'hBA) racc = ropd;
    else {racc, ropd} = {ropd, racc};
    rflg = flg(op[7:4] == 4'h9 ? ropd : racc);
    send(op);
    in_valid <= 1'b0;
    wait_hi(1);
    check_state();
  endtask
  task automatic ee_op(input logic load, input logic [10:0] a);
    logic [10:0] opc;
    logic [7:0]  b [4];
    int          pu;
    int          po;
    opc = pc;
    pu = pushes;
    po = pops;
    wait_cycles <= 4'(rnd8() & 8'h0B);
    send({4'hC, load, a[10:8]});
    send(a[7:0]);
    in_valid <= 1'b0;
    wait_hi(1);
    for (int i = 0; i < 4; i++) b[i] = u_mem.mem[a + i];
    chk(36'(push_pc), 36'(opc + 11'h002), "push pc");
    chk(36'((pushes - pu) * 16 + pops - po), 36'h11, "push and pop");
    if (load) ropd = {b[0][7] ? 4'hF : 4'h0, 1'b0, b[0][6:0], b[1], b[2], b[3]};
    else chk(36'({b[0], b[1], b[2], b[3]}),
             36'({racc[35:32] != 4'h0, racc[30:0]}), "stored");
    check_state();
  endtask
  task automatic other_op(input logic [7:0] op, input logic [7:0] arg, input int extra);
    send(op);
    if (op != 8'hE1) send(arg);
    for (int i = 0; i < extra; i++) send(8'hB9);
    in_valid <= 1'b0;
    wait_hi(2);
    chk(36'({other_opcode, other_operand}), 36'({op, op == 8'hE1 ? 8'h00 : arg}), "other");
    reg_op(8'hD7);
  endtask
  function automatic logic [10:0] raddr();
    return 11'({rnd8(), rnd8()} % 16'h07FD);
  endfunction
  // ****************************
  // Main sequence
  // ****************************
  initial begin
    int k;
    seed = 16'h0047;
    {in_valid, in_data, in_pc, wait_cycles, pc} = '0;
    reset_n = 1'b0;
    for (int i = 0; i < 6; i++) begin
      ops[i] = 8'hA0 + 8'(i);
      ops[6 + i] = 8'hA6 + 8'(i);
      ops[12 + i] = 8'h90 + 8'(i);
      ops[18 + i] = 8'h96 + 8'(i);
    end
    ops[24] = 8'hB9;
    ops[25] = 8'hBA;
    ops[26] = 8'hD7;
    for (int i = 0; i < 2048; i++) u_mem.mem[i] = {4'(rnd8() % 8'h0A), 4'(rnd8() % 8'h0A)};
    for (int i = 0; i < 8; i++) u_mem.mem[i] = (i == 4) ? 8'h80 : 8'h00;
    do_reset();
    check_state();
    ee_op(1'b1, 11'h004);
    reg_op(8'hBA);
    ropd = racc;
    rslot[3] = racc;
    rflg = flg(racc);
    send(8'hB9);
    send(8'hA3);
    in_valid <= 1'b0;
    wait_hi(1);
    check_state();
    for (int i = 0; i < 27; i++) begin
      ee_op(1'b1, raddr());
      reg_op(8'hD7);
      ee_op(1'b1, raddr());
      reg_op(ops[i]);
    end
    ee_op(1'b0, 11'h000);
    ee_op(1'b1, 11'h000);
    ee_op(1'b0, 11'h7FC);
    ee_op(1'b1, 11'h7FC);
    for (int i = 0; i < 120; i++) begin
      k = rnd8() % 8'h20;
      if (k < 27) reg_op(ops[k]);
      else ee_op(k < 30, raddr());
    end
    other_op(8'hE1, 8'h00, 0);
    other_op(8'h52, rnd8(), 0);
    other_op(8'h83, 8'h40, 0);
    other_op(8'hAF, 8'h12, 1);
    other_op(8'hF0, 8'h25, 4);
    other_op(8'hF0, 8'h33, 1);
    other_op(8'hF0, 8'h52, 0);
    send(8'hC1);
    send(8'h80);
    in_valid <= 1'b0;
    repeat (6) @(posedge clock);
    do_reset();
    check_state();
    reg_op(8'hA8);
    finish_test();
  end
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
endmodule
bind drt_decoder drt_decoder_chk u_chk (.*);

// ===== tb/drt_decoder_chk.sv
// Purpose: Port checks of the register transfer decoder
// Assumes: Bound to drt_decoder
// Notes:   One clock domain
`timescale 1ns/1ps
module drt_decoder_chk (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        in_ready,
  input wire logic        in_valid,
  input wire logic        ee_req,
  input wire logic        ee_we,
  input wire logic [10:0] ee_addr,
  input wire logic [7:0]  ee_wdata,
  input wire logic        ee_ack,
  input wire logic        stack_push,
  input wire logic        stack_pop,
  input wire logic        positive_flag,
  input wire logic        negative_flag,
  input wire logic        zero_flag,
  input wire logic [35:0] main_accumulator,
  input wire logic        instr_done,
  input wire logic        other_valid
);
  logic [2:0] ack_cnt_ff;
  logic [2:0] nxt_ack_cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ****************************
  // Byte counter and properties
  // ****************************
  always_comb begin
    nxt_ack_cnt = ack_cnt_ff;
    if (stack_push) begin
      nxt_ack_cnt = 3'h0;
    end else if (ee_req && ee_ack) begin
      nxt_ack_cnt = ack_cnt_ff + 3'h1;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ack_cnt_ff <= 3'h0;
    end else begin
      ack_cnt_ff <= nxt_ack_cnt;
    end
  end
  a_flag_code: assert property (
    zero_flag ? positive_flag && !negative_flag : positive_flag ^ negative_flag)
    else $error("flag combination wrong");
  a_req_holds: assert property (ee_req && !ee_ack |=> ee_req && $stable(ee_addr)
    && $stable(ee_we) && $stable(ee_wdata))
    else $error("request changed before ack");
  a_byte_step: assert property (ee_req && ee_ack && ack_cnt_ff < 3'h3 |=> ee_req
    && ee_addr == $past(ee_addr) + 11'h001 && ee_we == $past(ee_we))
    else $error("next byte address wrong");
  a_four_bytes: assert property (stack_pop |-> ack_cnt_ff == 3'h4)
    else $error("pop without four bytes");
  a_push_pop: assert property (stack_push |-> ##[3:1000] stack_pop)
    else $error("no pop after push");
  a_push_req: assert property (stack_push |=> ee_req && !stack_push)
    else $error("no request after push");
  a_ready_back: assert property (stack_pop |=> instr_done ##1 in_ready)
    else $error("no completion after pop");
  a_ee_kept: assert property (ee_req |=> $stable(main_accumulator)
    && $stable({positive_flag, negative_flag, zero_flag}))
    else $error("flags or accumulator moved");
  a_busy_refuse: assert property (ee_req |-> !in_ready)
    else $error("ready during transfer");
  a_done_pulse: assert property (instr_done && !(in_valid && in_ready) |=> !instr_done)
    else $error("done longer than one cycle");
  c_write: cover property (ee_req && ee_ack && ee_we);
  c_read: cover property (ee_req && ee_ack && !ee_we);
  c_other: cover property (other_valid);
  c_back: cover property (instr_done && in_valid && in_ready);
endmodule

// ===== tb/drt_eeprom_model.sv
// Purpose: Byte wide EEPROM beside the decoder
// Assumes: One ack pulse per held request
// Notes:   Wait cycles set by bench
`timescale 1ns/1ps
module drt_eeprom_model (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        ee_req,
  input  wire logic        ee_we,
  input  wire logic [10:0] ee_addr,
  input  wire logic [7:0]  ee_wdata,
  input  wire logic [3:0]  wait_cycles,
  output logic             ee_ack,
  output logic      [7:0]  ee_rdata
);
  logic [7:0] mem [2048];
  logic       ack_ff;
  logic [3:0] cnt_ff;
  logic [7:0] last_ff;
  // ****************************
  // Answer logic
  // ****************************
  assign ee_ack = ack_ff;
  assign ee_rdata = ack_ff ? mem[ee_addr] : ~last_ff;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
      cnt_ff <= 4'h0;
      last_ff <= 8'h5A;
    end else if (ack_ff) begin
      ack_ff <= 1'b0;
      cnt_ff <= wait_cycles;
      last_ff <= mem[ee_addr];
      if (ee_we) begin
        mem[ee_addr] <= ee_wdata;
      end
    end else if (ee_req && cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end else if (ee_req) begin
      ack_ff <= 1'b1;
    end
  end
endmodule
